// *** rtl/lcr_pkg.sv ***
// Constants shared by the line interface control register bank.
package lcr_pkg;
	// Register addresses on the control port.
	localparam logic [7:0] ADDR_RELAY = 8'h05;
	localparam logic [7:0] ADDR_BIAS = 8'h08;
	localparam logic [7:0] ADDR_TIMER_LO = 8'h1A;
	localparam logic [7:0] ADDR_REAL = 8'h21;
	localparam logic [7:0] ADDR_THERM = 8'h48;
	// Field positions in the relay and battery configuration register.
	localparam int RLY_BATT_BIT = 5;
	localparam int RLY_FIELD_LSB = 2;
	localparam int RLY_RAIL_IDX = 2;
	localparam int RLY_DRIVE_IDX = 1;
	localparam int RLY_GPO_IDX = 0;
	localparam logic [1:0] RLY_RSVD_HI = 2'h2;
	// Field positions in the bias register; override flags map to bits 7:4.
	localparam int BIAS_OVR_LSB = 4;
	localparam int OVR_STBY = 3;
	localparam int OVR_AUDIO_SQUELCH = 2;
	localparam int OVR_FILTER_CAP_BYPASS = 1;
	localparam int OVR_LINE_BIAS_ENABLE = 0;
	// Field positions in the thermal register.
	localparam int THERM_STAT_BIT = 7;
	localparam int THERM_SEL_BIT = 6;
	// Values after reset.
	localparam logic [2:0] RLY_RST = 3'h0;
	localparam logic [7:0] BIAS_RST = 8'h00;
	localparam logic [3:0] OVR_RST = 4'h0;
	localparam logic [7:0] TIMER_LO_RST = 8'h00;
	localparam logic THERM_SEL_RST = 1'b0;
	localparam logic [3:0] REAL_RST = 4'h0;
	// One timer count lasts 1.25 us; the clock period is 10 ns.
	localparam real TIMER_LSB_US = 1.25;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam int TICK_CYCLES = int'(TIMER_LSB_US * 1000.0 / CLK_PERIOD_NS);
	localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
endpackage

// *** rtl/lcr_regs.sv ***
// Per-channel relay, bias and silent-timer registers plus shared thermal and impedance registers.
// Contract
// - Hold silent timer low byte; high byte comes separately; one count is 1.25 us.
// - Relay register bits 7:6 always read binary 10.
// - Relay register bit 5 reads the battery switch pin level.
// - Bit 4 flags a fitted ringing rail; software keeps it correct.
// - Relay register bit 3 enables the relay driver output.
// - Relay register bit 2 drives the general output pin.
// - Bias bit 7 shows standby; a write overrides until next hook change.
// - Bias bit 6 shows squelch; a write overrides until next speed-up event.
// - Bias bit 5 shows filter bypass; a write overrides until next speed-up event.
// - Bias bit 4 is bias enable; a write overrides until next hook change.
// - Bias bits 3:2 select on-hook transmission bias, 4 to 16 mA.
// - Bias bits 1:0 select active off-hook bias, 4 to 16 mA.
// - Thermal bit 7 reads one after linefeed over-temperature shutdown.
// - Thermal bit 6 is protected and selects the power sensing method.
// - One thermal register for both channels; bits 5:0 read zero.
// - One real coefficient register for both channels in bits 3:0; upper zero.
// - The silent timer runs only while its enable is set.
// - A channel soft reset returns that channel's registers to defaults.
`timescale 1ns/100ps
module lcr_regs (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Register access port.
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_chan,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic protect_unlock,
	// Channel events and automatic status from the line logic.
	input wire logic [1:0] soft_reset,
	input wire logic [1:0] hook_change,
	input wire logic [1:0] speedup_event,
	input wire logic [1:0] auto_standby,
	input wire logic [1:0] auto_squelch,
	input wire logic [1:0] auto_cap_bypass,
	input wire logic [1:0] auto_bias_enable,
	// Pin levels from outside the clock domain.
	input wire logic [1:0] battery_switch_pin,
	input wire logic linefeed_overtemp,
	// Silent timer control.
	input wire logic [1:0] silence_timer_enable,
	input wire logic [1:0][7:0] ring_silence_timer_high,
	input wire logic [1:0] silence_start,
	output logic [1:0] silence_busy,
	output logic [1:0] silence_done,
	// Configuration outputs.
	output logic [1:0] ringing_rail_flag,
	output logic [1:0] relay_drive_enable,
	output logic [1:0] general_output_pin,
	output logic [1:0] low_power_standby,
	output logic [1:0] audio_squelch,
	output logic [1:0] filter_cap_bypass,
	output logic [1:0] line_bias_enable,
	output logic [1:0][1:0] onhook_tx_bias_level,
	output logic [1:0][1:0] active_bias_level,
	output logic power_sense_sel,
	output logic [3:0] real_coeff_field
);

	// A write aimed at one register of one channel.
	function automatic logic hit(input logic wr, input logic [7:0] a, input logic ch,
		input logic [7:0] tgt, input logic c);
		hit = wr && (a == tgt) && (ch == c);
	endfunction

	// Next value of an overridable bias bit.
	function automatic logic pick(input logic wr, input logic wv, input logic ovr,
		input logic keep, input logic auto_v);
		pick = wr ? wv : (ovr ? keep : auto_v);
	endfunction

	logic [1:0] batt_s1_ff;
	logic [1:0] batt_s2_ff;
	logic ot_s1_ff;
	logic ot_s2_ff;
	logic [2:0] rly_ff [2];
	logic [7:0] bias_ff [2];
	logic [3:0] ovr_ff [2];
	logic [7:0] tlo_ff [2];
	logic [15:0] cnt_ff [2];
	logic [6:0] tick_ff [2];
	logic [1:0] busy_ff;
	logic [1:0] done_ff;
	logic sel_ff;
	logic [3:0] rs_ff;
	logic [7:0] rdata_ff;
	logic [1:0] rly_wr;
	logic [1:0] bias_wr;
	logic [1:0] tlo_wr;
	logic [3:0] ev [2];
	logic [3:0] auto_v [2];

	// Two-stage synchronisers for the pin levels.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			batt_s1_ff <= 2'h0;
			batt_s2_ff <= 2'h0;
			ot_s1_ff <= 1'b0;
			ot_s2_ff <= 1'b0;
		end else begin
			batt_s1_ff <= battery_switch_pin;
			batt_s2_ff <= batt_s1_ff;
			ot_s1_ff <= linefeed_overtemp;
			ot_s2_ff <= ot_s1_ff;
		end
	end

	// Write decode per channel; bias writes need the unlock.
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			rly_wr[c] = hit(reg_wr, reg_addr, reg_chan, lcr_pkg::ADDR_RELAY, 1'(c));
			bias_wr[c] = hit(reg_wr, reg_addr, reg_chan, lcr_pkg::ADDR_BIAS, 1'(c))
				&& protect_unlock;
			tlo_wr[c] = hit(reg_wr, reg_addr, reg_chan, lcr_pkg::ADDR_TIMER_LO, 1'(c));
			ev[c] = {hook_change[c], speedup_event[c], speedup_event[c], hook_change[c]};
			auto_v[c] = {auto_standby[c], auto_squelch[c], auto_cap_bypass[c],
				auto_bias_enable[c]};
		end
	end

	// Relay configuration, one copy per channel.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int c = 0; c < 2; c++) begin
				rly_ff[c] <= lcr_pkg::RLY_RST;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (soft_reset[c]) begin
					rly_ff[c] <= lcr_pkg::RLY_RST;
				end else if (rly_wr[c]) begin
					rly_ff[c] <= reg_wdata[lcr_pkg::RLY_FIELD_LSB +: 3];
				end
			end
		end
	end

	// Bias register: bits 7:4 follow the line logic unless a write holds them.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int c = 0; c < 2; c++) begin
				bias_ff[c] <= lcr_pkg::BIAS_RST;
				ovr_ff[c] <= lcr_pkg::OVR_RST;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (soft_reset[c]) begin
					bias_ff[c] <= lcr_pkg::BIAS_RST;
					ovr_ff[c] <= lcr_pkg::OVR_RST;
				end else begin
					if (bias_wr[c]) begin
						bias_ff[c][3:0] <= reg_wdata[3:0];
					end
					for (int b = 0; b < 4; b++) begin
						// A write in the same cycle as the clearing event keeps the hold.
						ovr_ff[c][b] <= bias_wr[c] | (ovr_ff[c][b] & ~ev[c][b]);
						bias_ff[c][lcr_pkg::BIAS_OVR_LSB + b] <= pick(bias_wr[c],
							reg_wdata[lcr_pkg::BIAS_OVR_LSB + b], ovr_ff[c][b],
							bias_ff[c][lcr_pkg::BIAS_OVR_LSB + b], auto_v[c][b]);
					end
				end
			end
		end
	end

	// Silent timer low byte, one copy per channel.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int c = 0; c < 2; c++) begin
				tlo_ff[c] <= lcr_pkg::TIMER_LO_RST;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (soft_reset[c]) begin
					tlo_ff[c] <= lcr_pkg::TIMER_LO_RST;
				end else if (tlo_wr[c]) begin
					tlo_ff[c] <= reg_wdata;
				end
			end
		end
	end

	// Silent period countdown in 1.25 us steps, stopped while disabled.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			busy_ff <= 2'h0;
			done_ff <= 2'h0;
			for (int c = 0; c < 2; c++) begin
				cnt_ff[c] <= 16'h0000;
				tick_ff[c] <= 7'h00;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				done_ff[c] <= 1'b0;
				if (soft_reset[c] || !silence_timer_enable[c]) begin
					busy_ff[c] <= 1'b0;
					tick_ff[c] <= 7'h00;
				end else if (silence_start[c]) begin
					cnt_ff[c] <= {ring_silence_timer_high[c], tlo_ff[c]};
					tick_ff[c] <= 7'h00;
					busy_ff[c] <= 1'b1;
				end else if (busy_ff[c]) begin
					if (tick_ff[c] == lcr_pkg::TICK_LAST) begin
						tick_ff[c] <= 7'h00;
						if (cnt_ff[c] <= 16'h0001) begin
							busy_ff[c] <= 1'b0;
							done_ff[c] <= 1'b1;
						end else begin
							cnt_ff[c] <= cnt_ff[c] - 16'h0001;
						end
					end else begin
						tick_ff[c] <= tick_ff[c] + 7'h01;
					end
				end
			end
		end
	end

	// Shared thermal sense select and real coefficient.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sel_ff <= lcr_pkg::THERM_SEL_RST;
			rs_ff <= lcr_pkg::REAL_RST;
		end else begin
			if (reg_wr && reg_addr == lcr_pkg::ADDR_THERM && protect_unlock) begin
				sel_ff <= reg_wdata[lcr_pkg::THERM_SEL_BIT];
			end
			if (reg_wr && reg_addr == lcr_pkg::ADDR_REAL) begin
				rs_ff <= reg_wdata[3:0];
			end
		end
	end

	// Registered read data; unmapped addresses read zero.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				lcr_pkg::ADDR_RELAY: begin
					rdata_ff <= {lcr_pkg::RLY_RSVD_HI, batt_s2_ff[reg_chan],
						rly_ff[reg_chan], 2'h0};
				end
				lcr_pkg::ADDR_BIAS: rdata_ff <= bias_ff[reg_chan];
				lcr_pkg::ADDR_TIMER_LO: rdata_ff <= tlo_ff[reg_chan];
				lcr_pkg::ADDR_THERM: rdata_ff <= {ot_s2_ff, sel_ff, 6'h00};
				lcr_pkg::ADDR_REAL: rdata_ff <= {4'h0, rs_ff};
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	// Outputs taken straight from the registers.
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			ringing_rail_flag[c] = rly_ff[c][lcr_pkg::RLY_RAIL_IDX];
			relay_drive_enable[c] = rly_ff[c][lcr_pkg::RLY_DRIVE_IDX];
			general_output_pin[c] = rly_ff[c][lcr_pkg::RLY_GPO_IDX];
			low_power_standby[c] = bias_ff[c][lcr_pkg::BIAS_OVR_LSB + lcr_pkg::OVR_STBY];
			audio_squelch[c] = bias_ff[c][lcr_pkg::BIAS_OVR_LSB + lcr_pkg::OVR_AUDIO_SQUELCH];
			filter_cap_bypass[c] = bias_ff[c][lcr_pkg::BIAS_OVR_LSB + lcr_pkg::OVR_FILTER_CAP_BYPASS];
			line_bias_enable[c] = bias_ff[c][lcr_pkg::BIAS_OVR_LSB + lcr_pkg::OVR_LINE_BIAS_ENABLE];
			onhook_tx_bias_level[c] = bias_ff[c][3:2];
			active_bias_level[c] = bias_ff[c][1:0];
		end
	end
	assign reg_rdata = rdata_ff;
	assign silence_busy = busy_ff;
	assign silence_done = done_ff;
	assign power_sense_sel = sel_ff;
	assign real_coeff_field = rs_ff;

	// Checks on read data, overrides and the timer.
	AST_RLY_RSVD: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_rd && reg_addr == lcr_pkg::ADDR_RELAY |=> reg_rdata[7:6] == 2'h2 && reg_rdata[1:0] == 2'h0)
		else $error("relay reserved bits wrong");
	AST_BATT_READ: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_rd && reg_addr == lcr_pkg::ADDR_RELAY |=> reg_rdata[5] == $past(batt_s2_ff[reg_chan]))
		else $error("battery switch level misreported");
	AST_RELAY_DRIVE_ENABLE_WR: assert property (@(posedge core_clk) disable iff (!nrst)
		rly_wr[0] && !soft_reset[0] |=> relay_drive_enable[0] == $past(reg_wdata[3]))
		else $error("relay driver enable not taken");
	AST_GPO_WR: assert property (@(posedge core_clk) disable iff (!nrst)
		rly_wr[1] && !soft_reset[1] |=> general_output_pin[1] == $past(reg_wdata[2]))
		else $error("general output not taken");
	AST_STBY_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
		bias_wr[0] && !soft_reset[0] ##1 (!hook_change[0] && !bias_wr[0] && !soft_reset[0])
		|=> low_power_standby[0] == $past(low_power_standby[0]))
		else $error("standby override lost");
	AST_LINE_BIAS_ENABLE_REL: assert property (@(posedge core_clk) disable iff (!nrst)
		hook_change[0] && !bias_wr[0] && !soft_reset[0] ##1 (!bias_wr[0] && !soft_reset[0])
		|=> line_bias_enable[0] == $past(auto_bias_enable[0]))
		else $error("bias enable override not released");
	AST_SQ_REL: assert property (@(posedge core_clk) disable iff (!nrst)
		speedup_event[1] && !bias_wr[1] && !soft_reset[1] ##1 (!bias_wr[1] && !soft_reset[1])
		|=> audio_squelch[1] == $past(auto_squelch[1]))
		else $error("squelch override not released");
	AST_PROT: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_wr && reg_addr == lcr_pkg::ADDR_BIAS && !protect_unlock && !soft_reset[reg_chan]
		|=> $stable(active_bias_level[$past(reg_chan)]))
		else $error("locked bias write landed");
	AST_THERM_READ: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_rd && reg_addr == lcr_pkg::ADDR_THERM
		|=> reg_rdata[7] == $past(ot_s2_ff) && reg_rdata[5:0] == 6'h00)
		else $error("thermal read wrong");
	AST_REAL_READ: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_rd && reg_addr == lcr_pkg::ADDR_REAL |=> reg_rdata == {4'h0, $past(rs_ff)})
		else $error("real coefficient read wrong");
	AST_TIMER_EN: assert property (@(posedge core_clk) disable iff (!nrst)
		!silence_timer_enable[0] |=> !silence_busy[0] && !silence_done[0])
		else $error("timer ran while disabled");
	AST_TICK: assert property (@(posedge core_clk) disable iff (!nrst)
		silence_done[0] |-> $past(tick_ff[0]) == lcr_pkg::TICK_LAST && $past(busy_ff[0]))
		else $error("timer ended off a tick");
	AST_SOFT: assert property (@(posedge core_clk) disable iff (!nrst)
		soft_reset[1] |=> rly_ff[1] == 3'h0 && bias_ff[1] == 8'h00 && tlo_ff[1] == 8'h00)
		else $error("soft reset left state");
endmodule

// *** verification/lcr_host.sv ***
// Host model that drives the register port of the line interface register bank.
`timescale 1ns/100ps
module lcr_host (
	// Clock.
	input wire logic core_clk,
	// Register access port.
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_chan,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic protect_unlock,
	input wire logic [7:0] reg_rdata
);
	// Idle values at time zero; nothing is requested until a task runs.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_chan = 1'b0;
		reg_addr = 8'hFF;
		reg_wdata = 8'h00;
		protect_unlock = 1'b0;
	end
	// Opens or closes the window for protected writes.
	task automatic lock(input logic u);
		@(posedge core_clk);
		protect_unlock <= u;
	endtask
	// One write strobe; idle address and data move off their last value.
	task automatic wr(input logic c, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_chan <= c;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// One read strobe; the data is taken a cycle after the strobe is accepted.
	task automatic rd(input logic c, input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_chan <= c;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge core_clk);
		d = reg_rdata;
	endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the line interface register bank.
`timescale 1ns/100ps
module tb;
	logic core_clk, nrst, reg_wr, reg_rd, reg_chan, protect_unlock, linefeed_overtemp;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [1:0] soft_reset, hook_change, speedup_event, auto_standby, auto_squelch;
	logic [1:0] auto_cap_bypass, auto_bias_enable, battery_switch_pin, silence_timer_enable;
	logic [1:0] silence_start, silence_busy, silence_done, ringing_rail_flag, relay_drive_enable;
	logic [1:0] general_output_pin, low_power_standby, audio_squelch, filter_cap_bypass;
	logic [1:0] line_bias_enable;
	logic [1:0][1:0] onhook_tx_bias_level, active_bias_level;
	logic [1:0][7:0] ring_silence_timer_high;
	logic power_sense_sel, sel_m, ot_m;
	logic [3:0] real_coeff_field, real_m;
	logic [7:0] rly_m [2], lo_m [2], tlo_m [2];
	logic [3:0] ovr_m [2], hold_m [2], auto_m [2];
	int fails, tests_run, cnt, dn;
	lcr_regs lcr_regs_i (.core_clk, .nrst, .reg_wr, .reg_rd, .reg_chan, .reg_addr, .reg_wdata,
		.reg_rdata, .protect_unlock, .soft_reset, .hook_change, .speedup_event, .auto_standby,
		.auto_squelch, .auto_cap_bypass, .auto_bias_enable, .battery_switch_pin,
		.linefeed_overtemp, .silence_timer_enable, .ring_silence_timer_high, .silence_start,
		.silence_busy, .silence_done, .ringing_rail_flag, .relay_drive_enable, .general_output_pin,
		.low_power_standby, .audio_squelch, .filter_cap_bypass, .line_bias_enable,
		.onhook_tx_bias_level, .active_bias_level, .power_sense_sel, .real_coeff_field);
	lcr_host lcr_host_i (.core_clk, .reg_wr, .reg_rd, .reg_chan, .reg_addr, .reg_wdata,
		.protect_unlock, .reg_rdata);
	// Free-running 100 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Watchdog that cuts a hang short.
	initial begin
		#500000;
		fails++;
		end_of_test();
	end
	// Expected read value of a register, from the reference model.
	function automatic logic [7:0] exp_reg(input int c, input logic [7:0] a);
		case (a)
			lcr_pkg::ADDR_RELAY: return {2'b10, battery_switch_pin[c], rly_m[c][4:2], 2'b00};
			lcr_pkg::ADDR_BIAS: return {(ovr_m[c] & hold_m[c]) | (auto_m[c] & ~hold_m[c]),
				lo_m[c][3:0]};
			lcr_pkg::ADDR_TIMER_LO: return tlo_m[c];
			lcr_pkg::ADDR_REAL: return {4'h0, real_m};
			lcr_pkg::ADDR_THERM: return {ot_m, sel_m, 6'h00};
			default: return 8'h00;
		endcase
	endfunction
	// Compares one value and counts the result.
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Reads a register and compares it with the model.
	task automatic rd_chk(input int c, input logic [7:0] a);
		logic [7:0] v;
		lcr_host_i.rd(1'(c), a, v);
		check($sformatf("reg %h ch %0d", a, c), v, exp_reg(c, a));
	endtask
	// Reads every register of a channel, one unmapped place among them.
	task automatic check_all(input int c);
		logic [7:0] adr [6];
		adr = '{8'h05, 8'h08, 8'h1A, 8'h21, 8'h48, 8'h33};
		for (int i = 0; i < 6; i++) begin
			rd_chk(c, adr[i]);
		end
	endtask
	// Pulses one event line of a channel for one cycle.
	task automatic ev(input int k, input int c);
		@(posedge core_clk);
		case (k)
			0: hook_change <= 2'(1 << c);
			1: speedup_event <= 2'(1 << c);
			2: soft_reset <= 2'(1 << c);
			default: silence_start <= 2'(1 << c);
		endcase
		@(posedge core_clk);
		{hook_change, speedup_event, soft_reset, silence_start} <= 8'h00;
	endtask
	// Puts the model's automatic bias status onto the design inputs.
	task automatic apply_auto();
		@(posedge core_clk);
		auto_standby <= {auto_m[1][3], auto_m[0][3]};
		auto_squelch <= {auto_m[1][2], auto_m[0][2]};
		auto_cap_bypass <= {auto_m[1][1], auto_m[0][1]};
		auto_bias_enable <= {auto_m[1][0], auto_m[0][0]};
		repeat (2) @(posedge core_clk);
	endtask
	// Prints the verdict and ends the run.
	task automatic end_of_test();
		if (fails == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		nrst = 1'b0;
		{soft_reset, hook_change, speedup_event, silence_start, silence_timer_enable} = 10'h000;
		{auto_standby, auto_squelch, auto_cap_bypass, auto_bias_enable} = 8'h00;
		battery_switch_pin = 2'h0;
		linefeed_overtemp = 1'b0;
		ring_silence_timer_high = 16'h0000;
		{sel_m, ot_m, real_m} = 6'h00;
		for (int c = 0; c < 2; c++) begin
			{rly_m[c], lo_m[c], tlo_m[c], ovr_m[c], hold_m[c], auto_m[c]} = 36'h0;
		end
		void'($urandom(32'hE78F));
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		check_all(0);
		check_all(1);
		battery_switch_pin <= 2'($urandom);
		linefeed_overtemp <= 1'b1;
		ot_m = 1'b1;
		for (int c = 0; c < 2; c++) begin
			d = 8'($urandom);
			rly_m[c] = d;
			lcr_host_i.wr(1'(c), lcr_pkg::ADDR_RELAY, d);
		end
		for (int c = 0; c < 2; c++) begin
			rd_chk(c, lcr_pkg::ADDR_RELAY);
			check("relay out", {5'h00, ringing_rail_flag[c], relay_drive_enable[c],
				general_output_pin[c]}, {5'h00, rly_m[c][4:2]});
		end
		for (int c = 0; c < 2; c++) begin
			auto_m[c] = 4'($urandom);
			apply_auto();
			rd_chk(c, lcr_pkg::ADDR_BIAS);
			lcr_host_i.lock(1'b0);
			lcr_host_i.wr(1'(c), lcr_pkg::ADDR_BIAS, 8'hFF);
			rd_chk(c, lcr_pkg::ADDR_BIAS);
			lcr_host_i.lock(1'b1);
			for (int k = 0; k < 4; k++) begin
				d = {~auto_m[c], 2'(k), 2'(3 - k)};
				lcr_host_i.wr(1'(c), lcr_pkg::ADDR_BIAS, d);
				{ovr_m[c], lo_m[c], hold_m[c]} = {d[7:4], d, 4'hF};
				rd_chk(c, lcr_pkg::ADDR_BIAS);
				check("bias out", {low_power_standby[c], audio_squelch[c], filter_cap_bypass[c],
					line_bias_enable[c], onhook_tx_bias_level[c], active_bias_level[c]},
					d);
			end
			ev(0, c);
			hold_m[c] = hold_m[c] & 4'h6;
			repeat (2) @(posedge core_clk);
			rd_chk(c, lcr_pkg::ADDR_BIAS);
			ev(1, c);
			hold_m[c] = 4'h0;
			repeat (2) @(posedge core_clk);
			rd_chk(c, lcr_pkg::ADDR_BIAS);
		end
		lcr_host_i.wr(1'b1, lcr_pkg::ADDR_THERM, 8'hFF);
		sel_m = 1'b1;
		rd_chk(0, lcr_pkg::ADDR_THERM);
		check("sense sel", {7'h00, power_sense_sel}, 8'h01);
		lcr_host_i.lock(1'b0);
		lcr_host_i.wr(1'b0, lcr_pkg::ADDR_THERM, 8'h00);
		linefeed_overtemp <= 1'b0;
		ot_m = 1'b0;
		repeat (3) @(posedge core_clk);
		rd_chk(1, lcr_pkg::ADDR_THERM);
		d = 8'($urandom);
		real_m = d[3:0];
		lcr_host_i.wr(1'b0, lcr_pkg::ADDR_REAL, d);
		lcr_host_i.wr(1'b0, 8'h33, d);
		rd_chk(1, lcr_pkg::ADDR_REAL);
		check("real out", {4'h0, real_coeff_field}, {4'h0, real_m});
		rd_chk(0, 8'h33);
		lcr_host_i.wr(1'b0, lcr_pkg::ADDR_TIMER_LO, 8'h03);
		tlo_m[0] = 8'h03;
		rd_chk(0, lcr_pkg::ADDR_TIMER_LO);
		silence_timer_enable <= 2'b01;
		ring_silence_timer_high <= 16'h0001;
		ev(3, 0);
		cnt = 0;
		while (cnt < 40000) begin
			@(posedge core_clk);
			cnt++;
			#1;
			if (cnt == 1) begin
				check("busy run", {7'h00, silence_busy[0]}, 8'h01);
			end
			if (silence_done[0] === 1'b1) begin
				break;
			end
		end
		// High byte 0x01 and low byte 0x03 give 259 counts of 125 cycles each.
		check("silent len", {7'h00, cnt >= 259 * 125 && cnt <= 259 * 125 + 1}, 8'h01);
		check("busy end", {7'h00, silence_busy[0]}, 8'h00);
		ev(3, 1);
		dn = 0;
		repeat (500) begin
			@(posedge core_clk);
			#1 dn += (silence_done[1] !== 1'b0 || silence_busy[1] !== 1'b0);
		end
		check("timer off", 8'(dn), 8'h00);
		for (int c = 0; c < 2; c++) begin
			ev(2, c);
			{rly_m[c], lo_m[c], tlo_m[c], hold_m[c]} = 28'h0;
		end
		repeat (2) @(posedge core_clk);
		check_all(0);
		check_all(1);
		end_of_test();
	end
endmodule
